/* rtl/wmcp_port.sv */
/*
 * wmcp_port: single-character command interpreter of the wattmeter
 * serial port, with poll record generator and register port.
 * Assumes measurement fields arrive as ready-made ascii strings, right
 * justified, zero bytes meaning absent; rxd idles high, synchronous.
 */
`timescale 1ns/100ps
`include "wmcp_cfg.svh"
module wmcp_port
    import wmcp_pkg::*;
#(
    parameter int BIT_CYC   = `WMCP_BIT_CYC,
    parameter int MODE_NUM  = 4,
    parameter int FLD_LEN   = 8
)
(
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 clk_en,
    input  wire logic                 rxd,
    output logic                      txd,
    input  wire logic [8*FLD_LEN-1:0] power_str,
    input  wire logic [8*FLD_LEN-1:0] imped_str,
    input  wire logic [8*FLD_LEN-1:0] phase_str,
    input  wire logic [8*FLD_LEN-1:0] dbm_str,
    input  wire logic [8*FLD_LEN-1:0] swr_str,
    input  wire logic [1:0]           range_code,
    output logic [2:0]                alarm_sel,
    output logic [1:0]                mode_sel,
    output logic [1:0]                hold_sel,
    input  wire logic [3:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic [31:0]               reg_rdata,
    output logic                      irq
);
    localparam int NFLD = 9;

    wmcp_rx_state_t rx_state_q;
    logic [15:0]    rx_baud_q;
    logic [2:0]     rx_bit_q;
    logic [7:0]     rx_shift_q;
    logic           rx_stb;
    logic [7:0]     rx_byte;
    logic           rx_tick;
    logic           rx_half;

    logic [47:0]    call_q;
    logic           poll_en_q;
    logic [3:0]     irq_st_q;
    logic [3:0]     irq_mask_q;
    logic [3:0]     irq_set;

    logic           busy_q;
    logic           pend_q;
    logic [3:0]     fld_q;
    logic [3:0]     pos_q;
    logic [8*FLD_LEN-1:0] snap_q [NFLD];
    logic [3:0]     fld_len [NFLD];
    logic           fld_fixed [NFLD];
    logic [7:0]     cur_byte;
    logic           cur_skip;
    logic           tx_valid;
    logic           tx_ready;
    logic           last_pos;

    logic           cmd_alarm;
    logic           cmd_mode;
    logic           cmd_hold;
    logic           cmd_poll;

    // single digit field from a small code
    function automatic logic [8*FLD_LEN-1:0] digit_fld(input logic [2:0] v);
        digit_fld = {{(8*FLD_LEN-8){1'b0}}, `WMCP_CH_ZERO | {5'h00, v}};
    endfunction

    // receiver
    assign rx_tick = (rx_baud_q == 16'(BIT_CYC - 1));
    assign rx_half = (rx_baud_q == 16'(BIT_CYC / 2 - 1));

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            rx_baud_q <= 16'h0000;
        else if (clk_en)
        begin
            if (rx_state_q == WMCP_RX_IDLE || rx_tick ||
                (rx_state_q == WMCP_RX_START && rx_half))
                rx_baud_q <= 16'h0000;
            else
                rx_baud_q <= rx_baud_q + 16'h0001;
        end
    end

    // mid-bit sampling; stop bit must be high or byte dropped
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rx_state_q <= WMCP_RX_IDLE;
            rx_bit_q   <= 3'h0;
            rx_shift_q <= 8'h00;
            rx_stb     <= 1'b0;
            rx_byte    <= 8'h00;
        end
        else if (clk_en)
        begin
            rx_stb <= 1'b0;
            case (rx_state_q)
                WMCP_RX_IDLE:
                    if (!rxd)
                        rx_state_q <= WMCP_RX_START;
                WMCP_RX_START:
                    if (rx_half)
                    begin
                        rx_bit_q   <= 3'h0;
                        rx_state_q <= rxd ? WMCP_RX_IDLE : WMCP_RX_DATA;
                    end
                WMCP_RX_DATA:
                    if (rx_tick)
                    begin
                        rx_shift_q <= {rxd, rx_shift_q[7:1]};
                        rx_bit_q   <= rx_bit_q + 3'h1;
                        if (rx_bit_q == 3'h7)
                            rx_state_q <= WMCP_RX_STOP;
                    end
                default:
                    if (rx_tick)
                    begin
                        rx_state_q <= WMCP_RX_IDLE;
                        if (rxd)
                        begin
                            rx_stb  <= 1'b1;
                            rx_byte <= rx_shift_q;
                        end
                    end
            endcase
        end
    end

    // command decode
    // other characters fall through with no effect
    assign cmd_alarm = rx_stb && (rx_byte == `WMCP_CH_ALARM);
    assign cmd_mode  = rx_stb && (rx_byte == `WMCP_CH_MODE);
    assign cmd_hold  = rx_stb && (rx_byte == `WMCP_CH_HOLD);
    assign cmd_poll  = rx_stb && (rx_byte == `WMCP_CH_POLL) && poll_en_q;

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            alarm_sel <= 3'h0;
        else if (clk_en && cmd_alarm)
        begin
            if (alarm_sel == `WMCP_ALARM_MAX)
                alarm_sel <= 3'h0;
            else
                alarm_sel <= alarm_sel + 3'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            mode_sel <= 2'h0;
        else if (clk_en && cmd_mode)
        begin
            if (mode_sel == 2'(MODE_NUM - 1))
                mode_sel <= 2'h0;
            else
                mode_sel <= mode_sel + 2'h1;
        end
    end

    // 0 average, 1 peak, 2 tune
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            hold_sel <= 2'h0;
        else if (clk_en && cmd_hold)
        begin
            if (hold_sel == `WMCP_HOLD_MAX)
                hold_sel <= 2'h0;
            else
                hold_sel <= hold_sel + 2'h1;
        end
    end

    // poll record
    // field lengths: callsign fixed six, digits one, values variable
    always_comb
    begin
        for (int i = 0; i < NFLD; i++)
        begin
            fld_len[i]   = 4'(FLD_LEN);
            fld_fixed[i] = 1'b0;
        end
        fld_len[3]   = 4'h1;
        fld_len[4]   = 4'(`WMCP_CALL_LEN);
        fld_fixed[4] = 1'b1;
        fld_len[5]   = 4'h1;
        fld_len[6]   = 4'h1;
    end

    // pos 0 is the separator; positions index field msb first
    always_comb
    begin
        cur_byte = 8'h00;
        cur_skip = 1'b0;
        if (pos_q == 4'h0)
            cur_byte = (fld_q == 4'h0) ? `WMCP_CH_SEMI : `WMCP_CH_COMMA;
        else
        begin
            cur_byte = snap_q[fld_q][8*(fld_len[fld_q]-pos_q) +: 8];
            if (cur_byte == 8'h00)
            begin
                cur_byte = `WMCP_CH_SPACE;
                cur_skip = !fld_fixed[fld_q];
            end
        end
    end

    assign last_pos = (pos_q == fld_len[fld_q]);
    assign tx_valid = busy_q && !cur_skip;

    // snapshot at poll so the record stays consistent
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < NFLD; i++)
                snap_q[i] <= '0;
        end
        else if (clk_en && pend_q && !busy_q)
        begin
            snap_q[0] <= power_str;
            snap_q[1] <= imped_str;
            snap_q[2] <= phase_str;
            snap_q[3] <= digit_fld(alarm_sel);
            snap_q[4] <= {{(8*FLD_LEN-48){1'b0}}, call_q};
            snap_q[5] <= digit_fld({1'b0, range_code});
            snap_q[6] <= digit_fld({2'b00, hold_sel == 2'h1});
            snap_q[7] <= dbm_str;
            snap_q[8] <= swr_str;
        end
    end

    // poll during a record is kept and served after it
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            busy_q <= 1'b0;
            pend_q <= 1'b0;
            fld_q  <= 4'h0;
            pos_q  <= 4'h0;
        end
        else if (clk_en)
        begin
            if (cmd_poll)
                pend_q <= 1'b1;
            else if (pend_q && !busy_q)
                pend_q <= 1'b0;
            if (!busy_q && pend_q)
            begin
                busy_q <= 1'b1;
                fld_q  <= 4'h0;
                pos_q  <= 4'h0;
            end
            else if (busy_q && (cur_skip || tx_ready))
            begin
                if (!last_pos)
                    pos_q <= pos_q + 4'h1;
                else
                begin
                    pos_q <= 4'h0;
                    if (fld_q == 4'(NFLD - 1))
                        busy_q <= 1'b0;
                    else
                        fld_q <= fld_q + 4'h1;
                end
            end
        end
    end

    wmcp_uart_tx #(
        .BIT_CYC    (BIT_CYC)
    ) i_wmcp_uart_tx (
        .clk        (clk),
        .rst_b      (rst_b),
        .clk_en     (clk_en),
        .byte_valid (tx_valid),
        .byte_data  (cur_byte),
        .byte_ready (tx_ready),
        .txd        (txd)
    );

    // registers and interrupt
    assign irq_set = {cmd_poll, cmd_hold, cmd_mode, cmd_alarm};
    assign irq     = |(irq_st_q & irq_mask_q);

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            call_q     <= {6{`WMCP_CH_SPACE}};
            poll_en_q  <= 1'b1;
            irq_mask_q <= 4'h0;
        end
        else if (clk_en && reg_wr)
        begin
            if (reg_addr == `WMCP_REG_CTRL)
                poll_en_q <= reg_wdata[0];
            else if (reg_addr == `WMCP_REG_IRQ_MASK)
                irq_mask_q <= reg_wdata[3:0];
            else if (reg_addr == `WMCP_REG_CALL_LO)
                call_q[31:0] <= reg_wdata;
            else if (reg_addr == `WMCP_REG_CALL_HI)
                call_q[47:32] <= reg_wdata[15:0];
        end
    end

    // set wins over write-one-to-clear
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            irq_st_q <= 4'h0;
        else if (clk_en)
        begin
            if (reg_wr && reg_addr == `WMCP_REG_IRQ_ST)
                irq_st_q <= (irq_st_q & ~reg_wdata[3:0]) | irq_set;
            else
                irq_st_q <= irq_st_q | irq_set;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            reg_rdata <= 32'h0000_0000;
        else if (clk_en)
        begin
            reg_rdata <= 32'h0000_0000;
            if (reg_rd)
            begin
                if (reg_addr == `WMCP_REG_CTRL)
                    reg_rdata <= {31'h0000_0000, poll_en_q};
                else if (reg_addr == `WMCP_REG_STAT)
                    reg_rdata <= {22'h00_0000, pend_q, busy_q,
                                  hold_sel, mode_sel, 1'b0, alarm_sel};
                else if (reg_addr == `WMCP_REG_IRQ_ST)
                    reg_rdata <= {28'h000_0000, irq_st_q};
                else if (reg_addr == `WMCP_REG_IRQ_MASK)
                    reg_rdata <= {28'h000_0000, irq_mask_q};
                else if (reg_addr == `WMCP_REG_CALL_LO)
                    reg_rdata <= call_q[31:0];
                else if (reg_addr == `WMCP_REG_CALL_HI)
                    reg_rdata <= {16'h0000, call_q[47:32]};
            end
        end
    end
endmodule // wmcp_port

/* rtl/wmcp_cfg.svh */
/*
 * wmcp_cfg.svh: constants of the wattmeter serial command port
 * (uart timing, command characters, record layout, register map).
 * Assumes a 20 MHz clock; included by bare name.
 */
// How it works
// - link is 115200 baud, 8 data bits, no parity, one stop bit.
// - alarm-step character advances alarm set point Off,1.5,2.0,2.5,3.0.
// - mode-step character advances operating mode to the next one.
// - hold-cycle character steps display through average, peak, tune.
// - poll character sends a semicolon-led comma-separated ascii record.
// - fields: power, impedance, phase, alarm, callsign, range, hold, dbm, swr.
// - alarm field digit 0 off, 1..4 for 1.5 through 3.0.
// - callsign field is always six characters, space padded.
// - range field 0 high, 1 middle, 2 low.
// - hold field 0 when averaging, 1 when peak hold active.
`ifndef WMCP_CFG_SVH
`define WMCP_CFG_SVH

`define WMCP_CLK_HZ        20000000
`define WMCP_BAUD          115200
`define WMCP_BIT_CYC       ((`WMCP_CLK_HZ + `WMCP_BAUD / 2) / `WMCP_BAUD)
`define WMCP_DATA_BITS     8

`define WMCP_CH_ALARM      8'h41
`define WMCP_CH_MODE       8'h4D
`define WMCP_CH_HOLD       8'h46
`define WMCP_CH_POLL       8'h50
`define WMCP_CH_SEMI       8'h3B
`define WMCP_CH_COMMA      8'h2C
`define WMCP_CH_SPACE      8'h20
`define WMCP_CH_ZERO       8'h30

`define WMCP_ALARM_MAX     3'h4
`define WMCP_HOLD_MAX      2'h2
`define WMCP_CALL_LEN      6

`define WMCP_REG_CTRL      4'h0
`define WMCP_REG_STAT      4'h1
`define WMCP_REG_IRQ_ST    4'h2
`define WMCP_REG_IRQ_MASK  4'h3
`define WMCP_REG_CALL_LO   4'h4
`define WMCP_REG_CALL_HI   4'h5

`define WMCP_IRQ_ALARM     0
`define WMCP_IRQ_MODE      1
`define WMCP_IRQ_HOLD      2
`define WMCP_IRQ_POLL      3

`endif

/* rtl/wmcp_pkg.sv */
/*
 * wmcp_pkg: types of the wattmeter serial command port.
 * Assumes wmcp_cfg.svh is compiled with it.
 */
package wmcp_pkg;
    typedef enum logic [1:0]
    {
        WMCP_TX_IDLE  = 2'b00,
        WMCP_TX_START = 2'b01,
        WMCP_TX_DATA  = 2'b10,
        WMCP_TX_STOP  = 2'b11
    } wmcp_tx_state_t;

    typedef enum logic [1:0]
    {
        WMCP_RX_IDLE  = 2'b00,
        WMCP_RX_START = 2'b01,
        WMCP_RX_DATA  = 2'b10,
        WMCP_RX_STOP  = 2'b11
    } wmcp_rx_state_t;
endpackage

/* rtl/wmcp_uart_tx.sv */
/*
 * wmcp_uart_tx: 8n1 serial transmitter, one byte per request.
 * Assumes byte_valid is held until byte_ready; clock enable freezes it.
 */
`timescale 1ns/100ps
`include "wmcp_cfg.svh"
module wmcp_uart_tx
    import wmcp_pkg::*;
#(
    parameter int BIT_CYC = `WMCP_BIT_CYC
)
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    input  wire logic       byte_valid,
    input  wire logic [7:0] byte_data,
    output logic            byte_ready,
    output logic            txd
);
    wmcp_tx_state_t state_q;
    logic [15:0]    baud_q;
    logic [2:0]     bit_q;
    logic [7:0]     shift_q;
    logic           tick;

    assign tick       = (baud_q == 16'(BIT_CYC - 1));
    assign byte_ready = (state_q == WMCP_TX_IDLE);

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            baud_q <= 16'h0000;
        else if (clk_en)
        begin
            if (state_q == WMCP_TX_IDLE || tick)
                baud_q <= 16'h0000;
            else
                baud_q <= baud_q + 16'h0001;
        end
    end

    // start bit, 8 data lsb first, one stop, no parity
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state_q <= WMCP_TX_IDLE;
            bit_q   <= 3'h0;
            shift_q <= 8'h00;
            txd     <= 1'b1;
        end
        else if (clk_en)
        begin
            case (state_q)
                WMCP_TX_IDLE:
                    if (byte_valid)
                    begin
                        shift_q <= byte_data;
                        txd     <= 1'b0;
                        state_q <= WMCP_TX_START;
                    end
                WMCP_TX_START:
                    if (tick)
                    begin
                        txd     <= shift_q[0];
                        shift_q <= {1'b0, shift_q[7:1]};
                        bit_q   <= 3'h0;
                        state_q <= WMCP_TX_DATA;
                    end
                WMCP_TX_DATA:
                    if (tick)
                    begin
                        if (bit_q == 3'h7)
                        begin
                            txd     <= 1'b1;
                            state_q <= WMCP_TX_STOP;
                        end
                        else
                        begin
                            txd     <= shift_q[0];
                            shift_q <= {1'b0, shift_q[7:1]};
                            bit_q   <= bit_q + 3'h1;
                        end
                    end
                default:
                    if (tick)
                        state_q <= WMCP_TX_IDLE;
            endcase
        end
    end
endmodule // wmcp_uart_tx

/* testbench/wmcp_port_sva.sv */
/* wmcp_port_sva: port assertions for wmcp_port.
   Assumes a bind onto wmcp_port that hands on its parameters. */
`timescale 1ns/100ps
module wmcp_port_sva
    import wmcp_pkg::*;
#(
    parameter int BIT_CYC  = 174,
    parameter int MODE_NUM = 4
)
(
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       clk_en,
    input wire logic       rxd,
    input wire logic       txd,
    input wire logic [2:0] alarm_sel,
    input wire logic [1:0] mode_sel,
    input wire logic [1:0] hold_sel
);
    logic [15:0] low_q;
    logic [15:0] high_q;

    // lengths of the current low and high runs on txd
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            low_q  <= 16'h0000;
            high_q <= 16'h0000;
        end
        else if (clk_en)
        begin
            low_q  <= txd ? 16'h0000 : low_q + 16'h0001;
            high_q <= !txd ? 16'h0000 : high_q + {15'h0, ~&high_q};
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence sel_moved;
        $past(rst_b) && ($changed(alarm_sel) || $changed(mode_sel)
            || $changed(hold_sel));
    endsequence

    sequence stop_held;
        $past(rxd) && $past(rxd, 3);
    endsequence

    alarm_range_a: assert property (alarm_sel <= 3'h4)
        else $error("alarm selector out of range");
    alarm_step_a: assert property (
        $past(rst_b) && $changed(alarm_sel) |-> alarm_sel ==
        (($past(alarm_sel) == 3'h4) ? 3'h0 : $past(alarm_sel) + 3'h1))
        else $error("alarm selector stepped wrongly");
    mode_step_a: assert property (
        $past(rst_b) && $changed(mode_sel) |-> mode_sel ==
        (($past(mode_sel) == 2'(MODE_NUM - 1)) ? 2'h0
        : $past(mode_sel) + 2'h1))
        else $error("mode selector stepped wrongly");
    hold_step_a: assert property (
        $past(rst_b) && $changed(hold_sel) |-> hold_sel ==
        (($past(hold_sel) == 2'h2) ? 2'h0 : $past(hold_sel) + 2'h1))
        else $error("hold selector stepped wrongly");
    sel_at_stop_a: assert property (sel_moved |-> stop_held)
        else $error("selector moved outside a stop bit");
    txd_cell_a: assert property ($rose(txd) |-> low_q % BIT_CYC == 0)
        else $error("txd low run not whole bit cells");
    txd_low_max_a: assert property (low_q <= 16'(9 * BIT_CYC))
        else $error("txd low longer than start plus eight bits");
    txd_stop_a: assert property ($fell(txd) |-> high_q >= 16'(BIT_CYC))
        else $error("txd stop bit too short");
endmodule // wmcp_port_sva

/* testbench/wmcp_host_model.sv */
/* wmcp_host_model: host terminal on the serial pins; sends command
   characters and collects reply bytes. Assumes idle-high 8n1 lines. */
`timescale 1ns/100ps
module wmcp_host_model
#(
    parameter int BIT_CYC = 8
)
(
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd
);
    logic [7:0] rx_q [$];
    logic [7:0] rx_b;

    // data line only, no handshake pins
    initial rxd = 1'b1;

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            rxd <= frame[i];
            repeat (BIT_CYC) @(posedge clk);
        end
    endtask

    // mid-cell sampling; bytes with a bad stop bit are dropped
    always
    begin
        @(negedge txd);
        if (txd === 1'b0)
        begin
            repeat (BIT_CYC / 2) @(posedge clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT_CYC) @(posedge clk);
                rx_b[i] = txd;
            end
            repeat (BIT_CYC) @(posedge clk);
            if (txd === 1'b1)
                rx_q.push_back(rx_b);
        end
    end
endmodule // wmcp_host_model

/* testbench/test_wattmeter_serial_command_port.sv */
/* test_wattmeter_serial_command_port: self-checking bench of wmcp_port.
   Assumes the host model and checker files and wmcp_cfg.svh. */
`timescale 1ns/100ps
`include "wmcp_cfg.svh"
module test_wattmeter_serial_command_port
    import wmcp_pkg::*;
;
    localparam int BIT_CYC  = 8;
    localparam int MODE_NUM = 4;
    localparam int FLD_LEN  = 8;

    logic                 clk;
    logic                 rst_b;
    logic                 clk_en;
    logic                 rxd;
    logic                 txd;
    logic [8*FLD_LEN-1:0] power_str;
    logic [8*FLD_LEN-1:0] imped_str;
    logic [8*FLD_LEN-1:0] phase_str;
    logic [8*FLD_LEN-1:0] dbm_str;
    logic [8*FLD_LEN-1:0] swr_str;
    logic [1:0]           range_code;
    logic [2:0]           alarm_sel;
    logic [1:0]           mode_sel;
    logic [1:0]           hold_sel;
    logic [3:0]           reg_addr;
    logic [31:0]          reg_wdata;
    logic                 reg_wr;
    logic                 reg_rd;
    logic [31:0]          reg_rdata;
    logic                 irq;
    int                   n_fail;
    int                   n_compared;

    wmcp_port #(.BIT_CYC(BIT_CYC), .MODE_NUM(MODE_NUM), .FLD_LEN(FLD_LEN))
        i_wmcp_port
    (
        .clk        (clk),
        .rst_b      (rst_b),
        .clk_en     (clk_en),
        .rxd        (rxd),
        .txd        (txd),
        .power_str  (power_str),
        .imped_str  (imped_str),
        .phase_str  (phase_str),
        .dbm_str    (dbm_str),
        .swr_str    (swr_str),
        .range_code (range_code),
        .alarm_sel  (alarm_sel),
        .mode_sel   (mode_sel),
        .hold_sel   (hold_sel),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata),
        .reg_wr     (reg_wr),
        .reg_rd     (reg_rd),
        .reg_rdata  (reg_rdata),
        .irq        (irq)
    );

    wmcp_host_model #(.BIT_CYC(BIT_CYC)) i_wmcp_host_model
    (
        .clk (clk),
        .txd (txd),
        .rxd (rxd)
    );

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp,
                      input string what);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
        @(posedge clk);
    endtask

    task automatic irq_is(input logic exp);
        #1;
        chk("irq", {31'h0, exp}, {31'h0, irq});
        @(posedge clk);
    endtask

    task automatic send(input logic [7:0] ch);
        i_wmcp_host_model.send_byte(ch);
        repeat (4) @(posedge clk);
    endtask

    task automatic sels(input logic [2:0] a, input logic [1:0] m,
                        input logic [1:0] h);
        chk("alarm", {29'h0, a}, {29'h0, alarm_sel});
        chk("mode", {30'h0, m}, {30'h0, mode_sel});
        chk("hold", {30'h0, h}, {30'h0, hold_sel});
    endtask

    task automatic t_reset;
        sels(3'h0, 2'h0, 2'h0);
        chk("txd", 32'h1, {31'h0, txd});
        irq_is(1'b0);
        rd(`WMCP_REG_CTRL, 32'h0000_0001, "ctrl");
        rd(`WMCP_REG_IRQ_MASK, 32'h0, "mask");
        rd(`WMCP_REG_CALL_LO, 32'h2020_2020, "call lo");
        rd(`WMCP_REG_CALL_HI, 32'h0000_2020, "call hi");
        $display("t_reset done");
    endtask

    task automatic t_alarm;
        for (int i = 1; i <= 5; i++)
        begin
            send(`WMCP_CH_ALARM);
            sels(3'(i % 5), 2'h0, 2'h0);
        end
        $display("t_alarm done");
    endtask

    task automatic t_mode_hold;
        for (int i = 1; i <= MODE_NUM; i++)
        begin
            send(`WMCP_CH_MODE);
            sels(3'h0, 2'(i % MODE_NUM), 2'h0);
        end
        for (int i = 1; i <= 3; i++)
        begin
            send(`WMCP_CH_HOLD);
            sels(3'h0, 2'h0, 2'(i % 3));
        end
        $display("t_mode_hold done");
    endtask

    task automatic t_ignore;
        send(8'h5A);
        send(8'h70);
        // a write while frozen must not land
        clk_en <= 1'b0;
        wr(`WMCP_REG_IRQ_MASK, 32'h0000_000F);
        repeat (8) @(posedge clk);
        clk_en <= 1'b1;
        rd(`WMCP_REG_IRQ_MASK, 32'h0, "frozen mask");
        sels(3'h0, 2'h0, 2'h0);
        chk("replies", 32'h0, 32'(i_wmcp_host_model.rx_q.size()));
        $display("t_ignore done");
    endtask

    task automatic t_poll;
        string exp_s;
        int    n;
        exp_s = ";1457.00,49.3,005.0,2,ABCD  ,2,1,61.6,1.02";
        n = exp_s.len();
        power_str  <= 64'h0031_3435_372E_3030;
        imped_str  <= 64'h0000_0000_3439_2E33;
        phase_str  <= 64'h0000_0030_3035_2E30;
        dbm_str    <= 64'h0000_0000_3631_2E36;
        swr_str    <= 64'h0000_0000_312E_3032;
        range_code <= 2'h2;
        wr(`WMCP_REG_CALL_HI, 32'h0000_4142);
        wr(`WMCP_REG_CALL_LO, 32'h4344_0000);
        send(`WMCP_CH_ALARM);
        send(`WMCP_CH_ALARM);
        send(`WMCP_CH_HOLD);
        // second poll lands while the first record is still going out
        send(`WMCP_CH_POLL);
        send(`WMCP_CH_POLL);
        for (int k = 0; k < 20000; k++)
        begin
            if (i_wmcp_host_model.rx_q.size() >= 2 * n)
                break;
            @(posedge clk);
        end
        repeat (40 * BIT_CYC) @(posedge clk);
        chk("length", 32'(2 * n), 32'(i_wmcp_host_model.rx_q.size()));
        for (int i = 0; i < 2 * n; i++)
            chk("byte", {24'h0, exp_s[i % n]}, {24'h0, i_wmcp_host_model.rx_q[i]});
        wr(`WMCP_REG_CTRL, 32'h0);
        send(`WMCP_CH_POLL);
        repeat (20 * BIT_CYC) @(posedge clk);
        chk("quiet", 32'(2 * n), 32'(i_wmcp_host_model.rx_q.size()));
        $display("t_poll done");
    endtask

    task automatic t_regs;
        rd(`WMCP_REG_IRQ_ST, 32'h0000_000F, "irq status");
        irq_is(1'b0);
        wr(`WMCP_REG_IRQ_MASK, 32'h0000_0008);
        irq_is(1'b1);
        wr(`WMCP_REG_IRQ_ST, 32'h0000_0008);
        irq_is(1'b0);
        rd(`WMCP_REG_IRQ_ST, 32'h0000_0007, "irq status");
        rd(`WMCP_REG_STAT, 32'h0000_0042, "status");
        wr(4'hF, 32'hFFFF_FFFF);
        rd(4'hF, 32'h0, "unmapped");
        rd(`WMCP_REG_CTRL, 32'h0, "ctrl");
        $display("t_regs done");
    endtask

    task automatic conclude;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        n_fail++;
        $display("watchdog expired");
        conclude;
    end

    initial
    begin
        {rst_b, reg_wr, reg_rd, range_code} = '0;
        {power_str, imped_str, phase_str, dbm_str, swr_str} = '0;
        {reg_addr, reg_wdata} = '0;
        clk_en = 1'b1;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset;
        t_alarm;
        t_mode_hold;
        t_ignore;
        t_poll;
        t_regs;
        conclude;
    end
endmodule // test_wattmeter_serial_command_port

bind wmcp_port wmcp_port_sva #(.BIT_CYC(BIT_CYC), .MODE_NUM(MODE_NUM))
    i_wmcp_port_sva
(
    .clk       (clk),
    .rst_b     (rst_b),
    .clk_en    (clk_en),
    .rxd       (rxd),
    .txd       (txd),
    .alarm_sel (alarm_sel),
    .mode_sel  (mode_sel),
    .hold_sel  (hold_sel)
);
